//--- cpu_register_set_pkg.sv
// Purpose: Constants, types and decode helpers for the processor register set.
// Assumes: A 32-bit Wishbone word bus; byte addresses on the bus.
// Notes:   Architecturally undefined reset values are forced to zero here.
package cpu_register_set_pkg;

    // Sizes.
    localparam int DATA_W   = 32;
    localparam int IDX_W    = 4;
    localparam int GR_COUNT = 16;
    localparam int ADDR_W   = 8;
    localparam int SEL_W    = 4;

    typedef logic [DATA_W-1:0] word_type;
    typedef logic [IDX_W-1:0]  idx_type;
    typedef logic [ADDR_W-1:0] addr_type;

    // Fixed roles of general registers.
    localparam idx_type INDEX_REG = 4'h0;
    localparam idx_type STACK_REG = 4'hF;

    // Register offsets (byte addresses).
    localparam addr_type OFS_STATUS = 8'h00;
    localparam addr_type OFS_GBASE  = 8'h04;
    localparam addr_type OFS_VBASE  = 8'h08;
    localparam addr_type OFS_MAC_HI = 8'h0C;
    localparam addr_type OFS_MAC_LO = 8'h10;
    localparam addr_type OFS_LINK   = 8'h14;
    localparam addr_type OFS_PC     = 8'h18;
    localparam logic [1:0] GR_WINDOW = 2'h1;
    localparam int GR_IDX_LSB        = 2;
    localparam int GR_WIN_LSB        = 6;

    // Status word layout: carry 0, sat 1, mask 7:4, q 8, m 9.
    localparam int STATUS_MASK_LSB      = 4;
    localparam int STATUS_MASK_W        = 4;
    localparam word_type STATUS_IMPL    = 32'h0000_03F3;
    localparam word_type STATUS_RESET   = 32'h0000_00F0;
    localparam word_type VBASE_RESET    = 32'h0000_0000;
    localparam word_type UNDEF_RESET    = 32'h0000_0000;
    localparam word_type UNMAPPED_READ  = 32'h0000_0000;

    typedef enum {SEL_NONE, SEL_STATUS, SEL_GBASE, SEL_VBASE,
                  SEL_MAC_HI, SEL_MAC_LO, SEL_LINK, SEL_PC, SEL_GR} reg_sel_type;

    // Maps an address onto the register it selects.
    function automatic reg_sel_type decode_sel(input addr_type adr);
        reg_sel_type s;
        s = SEL_NONE;
        if (adr[ADDR_W-1:GR_WIN_LSB] == GR_WINDOW) begin
            s = SEL_GR;
        end else if (adr == OFS_STATUS) begin
            s = SEL_STATUS;
        end else if (adr == OFS_GBASE) begin
            s = SEL_GBASE;
        end else if (adr == OFS_VBASE) begin
            s = SEL_VBASE;
        end else if (adr == OFS_MAC_HI) begin
            s = SEL_MAC_HI;
        end else if (adr == OFS_MAC_LO) begin
            s = SEL_MAC_LO;
        end else if (adr == OFS_LINK) begin
            s = SEL_LINK;
        end else if (adr == OFS_PC) begin
            s = SEL_PC;
        end
        return s;
    endfunction

    // Replaces only the byte lanes whose select bit is set.
    function automatic word_type merge_lanes(input word_type old_w, input word_type new_w,
                                             input logic [SEL_W-1:0] sel);
        word_type m;
        m = old_w;
        for (int i = 0; i < SEL_W; i++) begin
            if (sel[i]) begin
                m[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return m;
    endfunction

endpackage

//--- bus_ack_unit.sv
// Purpose: Acknowledge generator for a classic Wishbone slave.
// Assumes: The master holds cyc and stb until it sees ack.
// Notes:   Ack is a one-cycle pulse, one cycle after the request is taken.
`timescale 1ns/1ns
`default_nettype none
module bus_ack_unit (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Bus handshake.
    input  wire logic cyc,
    input  wire logic stb,
    output logic      take,
    output logic      ack
);

    typedef struct packed {
        logic ack;
    } ack_state_type;

    ack_state_type state_q;
    ack_state_type state_d;

    // A request is taken once; the cycle of the ack blocks a second take.
    always_comb begin
        take = cyc & stb & ~state_q.ack;
        state_d = state_q;
        state_d.ack = take;
    end

    // Registers the handshake state.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign ack = state_q.ack;

    ack_pulse_one_a: assert property (@(posedge clk) disable iff (rst)
        ack |=> !ack)
        else $error("Bus ack held longer than one cycle.");

    ack_follows_take_a: assert property (@(posedge clk) disable iff (rst)
        (cyc && stb && !ack) |=> ack)
        else $error("Bus ack missing after a taken request.");

endmodule
`default_nettype wire

//--- general_register_bank.sv
// Purpose: Sixteen general registers with registered core read ports.
// Assumes: Index and data inputs are synchronous to clk.
// Notes:   Stack load beats core write, which beats bus write.
`timescale 1ns/1ns
`default_nettype none
module general_register_bank (
    // Clock and reset.
    input  wire logic                           clk,
    input  wire logic                           rst,
    // Stack pointer load from the vector table.
    input  wire logic                           sp_load,
    input  wire cpu_register_set_pkg::word_type sp_value,
    // Core write port.
    input  wire logic                           core_wr_en,
    input  wire cpu_register_set_pkg::idx_type  core_wr_idx,
    input  wire cpu_register_set_pkg::word_type core_wr_data,
    // Bus access port.
    input  wire logic                           bus_wr_en,
    input  wire cpu_register_set_pkg::idx_type  bus_idx,
    input  wire cpu_register_set_pkg::word_type bus_wr_data,
    output cpu_register_set_pkg::word_type      bus_rd_data,
    // Core read ports.
    input  wire cpu_register_set_pkg::idx_type  rd_a_idx,
    input  wire cpu_register_set_pkg::idx_type  rd_b_idx,
    output cpu_register_set_pkg::word_type      rd_a_data,
    output cpu_register_set_pkg::word_type      rd_b_data,
    output cpu_register_set_pkg::word_type      index_data,
    output cpu_register_set_pkg::word_type      stack_ptr
);

    typedef struct packed {
        cpu_register_set_pkg::word_type [cpu_register_set_pkg::GR_COUNT-1:0] gr;
        cpu_register_set_pkg::word_type rd_a;
        cpu_register_set_pkg::word_type rd_b;
    } bank_state_type;

    bank_state_type state_q;
    bank_state_type state_d;

    // Reads show the value before any write of the same edge.
    always_comb begin
        state_d = state_q;
        state_d.rd_a = state_q.gr[rd_a_idx];
        state_d.rd_b = state_q.gr[rd_b_idx];
        if (bus_wr_en) begin
            state_d.gr[bus_idx] = bus_wr_data;
        end
        if (core_wr_en) begin
            state_d.gr[core_wr_idx] = core_wr_data;
        end
        if (sp_load) begin
            state_d.gr[cpu_register_set_pkg::STACK_REG] = sp_value;
        end
    end

    // Contents are undefined for software; zero is only a safe start.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign bus_rd_data = state_q.gr[bus_idx];
    assign rd_a_data   = state_q.rd_a;
    assign rd_b_data   = state_q.rd_b;
    assign index_data  = state_q.gr[cpu_register_set_pkg::INDEX_REG];
    assign stack_ptr   = state_q.gr[cpu_register_set_pkg::STACK_REG];

    stack_load_value_a: assert property (@(posedge clk) disable iff (rst)
        sp_load |=> stack_ptr == $past(sp_value))
        else $error("Stack pointer did not take the vector value.");

    read_port_a_a: assert property (@(posedge clk) disable iff (rst)
        (core_wr_en && !sp_load) ##1 (rd_a_idx == $past(core_wr_idx))
        |=> rd_a_data == $past(core_wr_data, 2))
        else $error("Read port A lost a written value.");

endmodule
`default_nettype wire

//--- cpu_register_set.sv
// Purpose: Register set of the processor core with a Wishbone view.
// Assumes: Core ports and bus are synchronous to REF_CLK at 50 MHz.
// Notes:   Vector load beats exception restore, multiply, core and bus writes.
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module cpu_register_set (
    // Clock and reset.
    input  wire logic                              REF_CLK,
    input  wire logic                              RST,
    // Wishbone slave.
    input  wire logic                              WB_CYC_I,
    input  wire logic                              WB_STB_I,
    input  wire logic                              WB_WE_I,
    input  wire cpu_register_set_pkg::addr_type    WB_ADR_I,
    input  wire logic [cpu_register_set_pkg::SEL_W-1:0] WB_SEL_I,
    input  wire cpu_register_set_pkg::word_type    WB_DAT_I,
    output cpu_register_set_pkg::word_type         WB_DAT_O,
    output logic                                   WB_ACK_O,
    // Vector table load after reset.
    input  wire logic                              VEC_LOAD,
    input  wire cpu_register_set_pkg::word_type    VEC_SP,
    input  wire cpu_register_set_pkg::word_type    VEC_PC,
    // General register ports.
    input  wire logic                              GR_WR_EN,
    input  wire cpu_register_set_pkg::idx_type     GR_WR_IDX,
    input  wire cpu_register_set_pkg::word_type    GR_WR_DATA,
    input  wire cpu_register_set_pkg::idx_type     GR_RD_A_IDX,
    input  wire cpu_register_set_pkg::idx_type     GR_RD_B_IDX,
    output cpu_register_set_pkg::word_type         GR_RD_A_DATA,
    output cpu_register_set_pkg::word_type         GR_RD_B_DATA,
    output cpu_register_set_pkg::word_type         INDEX_DATA,
    output cpu_register_set_pkg::word_type         STACK_PTR,
    // Control and system register write port.
    input  wire logic                              CTL_WR_EN,
    input  wire cpu_register_set_pkg::addr_type    CTL_WR_ADDR,
    input  wire cpu_register_set_pkg::word_type    CTL_WR_DATA,
    // Multiply result write.
    input  wire logic                              MAC_WR_EN,
    input  wire cpu_register_set_pkg::word_type    MAC_HIGH_IN,
    input  wire cpu_register_set_pkg::word_type    MAC_LOW_IN,
    // Exception return restore.
    input  wire logic                              RESTORE_EN,
    input  wire cpu_register_set_pkg::word_type    RESTORE_STATUS,
    input  wire cpu_register_set_pkg::word_type    RESTORE_PC,
    // Register contents.
    output cpu_register_set_pkg::word_type         STATUS_WORD,
    output logic [cpu_register_set_pkg::STATUS_MASK_W-1:0] INTERRUPT_MASK_BITS,
    output cpu_register_set_pkg::word_type         GLOBAL_BASE,
    output cpu_register_set_pkg::word_type         VECTOR_BASE,
    output cpu_register_set_pkg::word_type         MAC_HIGH,
    output cpu_register_set_pkg::word_type         MAC_LOW,
    output cpu_register_set_pkg::word_type         SUB_LINK,
    output cpu_register_set_pkg::word_type         PROG_COUNTER
);

    typedef struct packed {
        cpu_register_set_pkg::word_type status;
        cpu_register_set_pkg::word_type gbase;
        cpu_register_set_pkg::word_type vbase;
        cpu_register_set_pkg::word_type mac_hi;
        cpu_register_set_pkg::word_type mac_lo;
        cpu_register_set_pkg::word_type link;
        cpu_register_set_pkg::word_type pc;
        cpu_register_set_pkg::word_type bus_dat;
    } top_state_type;

    top_state_type state_q;
    top_state_type state_d;

    logic                                take;
    logic                                bus_wr;
    logic                                gr_bus_wr;
    cpu_register_set_pkg::reg_sel_type   bus_sel;
    cpu_register_set_pkg::reg_sel_type   core_sel;
    cpu_register_set_pkg::idx_type       bus_idx;
    cpu_register_set_pkg::word_type      gr_bus_rd;
    cpu_register_set_pkg::word_type      gr_bus_wdat;

    // Handshake for the bus.
    bus_ack_unit u_ack (
        .clk  (REF_CLK),
        .rst  (RST),
        .cyc  (WB_CYC_I),
        .stb  (WB_STB_I),
        .take (take),
        .ack  (WB_ACK_O)
    );

    // Decodes both access paths with one map.
    always_comb begin
        bus_sel     = cpu_register_set_pkg::decode_sel(WB_ADR_I);
        core_sel    = cpu_register_set_pkg::decode_sel(CTL_WR_ADDR);
        bus_idx     = WB_ADR_I[cpu_register_set_pkg::GR_IDX_LSB +: cpu_register_set_pkg::IDX_W];
        bus_wr      = take & WB_WE_I;
        gr_bus_wr   = bus_wr & (bus_sel == cpu_register_set_pkg::SEL_GR);
        gr_bus_wdat = cpu_register_set_pkg::merge_lanes(gr_bus_rd, WB_DAT_I, WB_SEL_I);
    end

    // The general registers.
    general_register_bank u_bank (
        .clk          (REF_CLK),
        .rst          (RST),
        .sp_load      (VEC_LOAD),
        .sp_value     (VEC_SP),
        .core_wr_en   (GR_WR_EN),
        .core_wr_idx  (GR_WR_IDX),
        .core_wr_data (GR_WR_DATA),
        .bus_wr_en    (gr_bus_wr),
        .bus_idx      (bus_idx),
        .bus_wr_data  (gr_bus_wdat),
        .bus_rd_data  (gr_bus_rd),
        .rd_a_idx     (GR_RD_A_IDX),
        .rd_b_idx     (GR_RD_B_IDX),
        .rd_a_data    (GR_RD_A_DATA),
        .rd_b_data    (GR_RD_B_DATA),
        .index_data   (INDEX_DATA),
        .stack_ptr    (STACK_PTR)
    );

    // Next state: read capture, then writers in rising priority order.
    always_comb begin
        state_d = state_q;
        // Bus read data is captured at the edge that takes the request.
        if (take) begin
            case (bus_sel)
                cpu_register_set_pkg::SEL_STATUS: state_d.bus_dat = state_q.status;
                cpu_register_set_pkg::SEL_GBASE:  state_d.bus_dat = state_q.gbase;
                cpu_register_set_pkg::SEL_VBASE:  state_d.bus_dat = state_q.vbase;
                cpu_register_set_pkg::SEL_MAC_HI: state_d.bus_dat = state_q.mac_hi;
                cpu_register_set_pkg::SEL_MAC_LO: state_d.bus_dat = state_q.mac_lo;
                cpu_register_set_pkg::SEL_LINK:   state_d.bus_dat = state_q.link;
                cpu_register_set_pkg::SEL_PC:     state_d.bus_dat = state_q.pc;
                cpu_register_set_pkg::SEL_GR:     state_d.bus_dat = gr_bus_rd;
                default:                          state_d.bus_dat = cpu_register_set_pkg::UNMAPPED_READ;
            endcase
        end
        // Bus writes honour byte lanes; status keeps reserved bits clear.
        if (bus_wr) begin
            case (bus_sel)
                cpu_register_set_pkg::SEL_STATUS: begin
                    state_d.status = cpu_register_set_pkg::merge_lanes(state_q.status, WB_DAT_I, WB_SEL_I)
                                     & cpu_register_set_pkg::STATUS_IMPL;
                end
                cpu_register_set_pkg::SEL_GBASE: begin
                    state_d.gbase = cpu_register_set_pkg::merge_lanes(state_q.gbase, WB_DAT_I, WB_SEL_I);
                end
                cpu_register_set_pkg::SEL_VBASE: begin
                    state_d.vbase = cpu_register_set_pkg::merge_lanes(state_q.vbase, WB_DAT_I, WB_SEL_I);
                end
                cpu_register_set_pkg::SEL_MAC_HI: begin
                    state_d.mac_hi = cpu_register_set_pkg::merge_lanes(state_q.mac_hi, WB_DAT_I, WB_SEL_I);
                end
                cpu_register_set_pkg::SEL_MAC_LO: begin
                    state_d.mac_lo = cpu_register_set_pkg::merge_lanes(state_q.mac_lo, WB_DAT_I, WB_SEL_I);
                end
                cpu_register_set_pkg::SEL_LINK: begin
                    state_d.link = cpu_register_set_pkg::merge_lanes(state_q.link, WB_DAT_I, WB_SEL_I);
                end
                cpu_register_set_pkg::SEL_PC: begin
                    state_d.pc = cpu_register_set_pkg::merge_lanes(state_q.pc, WB_DAT_I, WB_SEL_I);
                end
                default: begin
                end
            endcase
        end
        // Core writes whole words to control and system registers.
        if (CTL_WR_EN) begin
            case (core_sel)
                cpu_register_set_pkg::SEL_STATUS: begin
                    state_d.status = CTL_WR_DATA & cpu_register_set_pkg::STATUS_IMPL;
                end
                cpu_register_set_pkg::SEL_GBASE: state_d.gbase = CTL_WR_DATA;
                cpu_register_set_pkg::SEL_VBASE: state_d.vbase = CTL_WR_DATA;
                cpu_register_set_pkg::SEL_MAC_HI: state_d.mac_hi = CTL_WR_DATA;
                cpu_register_set_pkg::SEL_MAC_LO: state_d.mac_lo = CTL_WR_DATA;
                cpu_register_set_pkg::SEL_LINK:  state_d.link  = CTL_WR_DATA;
                cpu_register_set_pkg::SEL_PC:    state_d.pc    = CTL_WR_DATA;
                default: begin
                end
            endcase
        end
        // Multiply results fill both halves together.
        if (MAC_WR_EN) begin
            state_d.mac_hi = MAC_HIGH_IN;
            state_d.mac_lo = MAC_LOW_IN;
        end
        // Exception return loads status and counter from the restore inputs.
        if (RESTORE_EN) begin
            state_d.status = RESTORE_STATUS & cpu_register_set_pkg::STATUS_IMPL;
            state_d.pc     = RESTORE_PC;
        end
        // Reset fetch of the start address.
        if (VEC_LOAD) begin
            state_d.pc = VEC_PC;
        end
    end

    // Undefined registers still start from a known value.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state_q.status  <= cpu_register_set_pkg::STATUS_RESET;
            state_q.gbase   <= cpu_register_set_pkg::UNDEF_RESET;
            state_q.vbase   <= cpu_register_set_pkg::VBASE_RESET;
            state_q.mac_hi  <= cpu_register_set_pkg::UNDEF_RESET;
            state_q.mac_lo  <= cpu_register_set_pkg::UNDEF_RESET;
            state_q.link    <= cpu_register_set_pkg::UNDEF_RESET;
            state_q.pc      <= cpu_register_set_pkg::UNDEF_RESET;
            state_q.bus_dat <= cpu_register_set_pkg::UNMAPPED_READ;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs come straight from the state registers.
    assign WB_DAT_O            = state_q.bus_dat;
    assign STATUS_WORD         = state_q.status;
    assign INTERRUPT_MASK_BITS = state_q.status[cpu_register_set_pkg::STATUS_MASK_LSB +:
                                                cpu_register_set_pkg::STATUS_MASK_W];
    assign GLOBAL_BASE         = state_q.gbase;
    assign VECTOR_BASE         = state_q.vbase;
    assign MAC_HIGH            = state_q.mac_hi;
    assign MAC_LOW             = state_q.mac_lo;
    assign SUB_LINK            = state_q.link;
    assign PROG_COUNTER        = state_q.pc;

    status_reserved_zero_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (STATUS_WORD & ~cpu_register_set_pkg::STATUS_IMPL) == 32'h0000_0000)
        else $error("Reserved status bits are not zero.");

    vector_pc_load_a: assert property (@(posedge REF_CLK) disable iff (RST)
        VEC_LOAD |=> PROG_COUNTER == $past(VEC_PC))
        else $error("Program counter missed the vector value.");

    mac_pair_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
        MAC_WR_EN |=> (MAC_HIGH == $past(MAC_HIGH_IN)) && (MAC_LOW == $past(MAC_LOW_IN)))
        else $error("Multiply result not stored in the pair.");

    restore_status_pc_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (RESTORE_EN && !VEC_LOAD) |=> (PROG_COUNTER == $past(RESTORE_PC))
        && (STATUS_WORD == ($past(RESTORE_STATUS) & cpu_register_set_pkg::STATUS_IMPL)))
        else $error("Exception restore did not load status and counter.");

    gbase_core_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (CTL_WR_EN && (core_sel == cpu_register_set_pkg::SEL_GBASE))
        |=> GLOBAL_BASE == $past(CTL_WR_DATA))
        else $error("Global base did not take the core write.");

    vbase_bus_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (bus_wr && (bus_sel == cpu_register_set_pkg::SEL_VBASE) && !CTL_WR_EN && (WB_SEL_I == 4'hF))
        |=> ##1 (WB_ACK_O == 1'b0) && (VECTOR_BASE == $past(WB_DAT_I, 2)))
        else $error("Vector base did not take the bus write.");

    read_data_with_ack_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (take && !WB_WE_I && (bus_sel == cpu_register_set_pkg::SEL_STATUS) && !CTL_WR_EN && !RESTORE_EN)
        |=> WB_ACK_O && (WB_DAT_O == STATUS_WORD))
        else $error("Status read data wrong at ack.");

endmodule
`default_nettype wire

//--- cpu_core_model.sv
// Purpose: Core-side model that loads vectors and writes results.
// Assumes: The register set takes each strobe at one rising edge.
// Notes:   Released data lines except GR_WR_IDX show the inverse of the last value; GR_WR_IDX keeps it.
`timescale 1ns/1ns
`default_nettype none
module cpu_core_model (
    // Clock.
    input  wire logic   REF_CLK,
    // Strobes.
    output logic        VEC_LOAD,
    output logic        GR_WR_EN,
    output logic        MAC_WR_EN,
    // Data.
    output logic [3:0]  GR_WR_IDX,
    output logic [31:0] VEC_SP,
    output logic [31:0] VEC_PC,
    output logic [31:0] GR_WR_DATA,
    output logic [31:0] MAC_HIGH_IN,
    output logic [31:0] MAC_LOW_IN
);
    // Starts idle.
    initial begin
        {VEC_LOAD, GR_WR_EN, MAC_WR_EN} = 3'h0;
        {GR_WR_IDX, VEC_SP, VEC_PC, GR_WR_DATA, MAC_HIGH_IN, MAC_LOW_IN} = '0;
    end
    // One strobe for one cycle: 0 vector load, 1 register write, 2 multiply result.
    task automatic issue(input int k, input logic [3:0] i, input logic [31:0] a, input logic [31:0] b);
        @(posedge REF_CLK);
        {VEC_LOAD, GR_WR_EN, MAC_WR_EN} <= {k == 0, k == 1, k == 2};
        {GR_WR_IDX, VEC_SP, VEC_PC, GR_WR_DATA, MAC_HIGH_IN, MAC_LOW_IN} <= {i, a, b, a, a, b};
        @(posedge REF_CLK);
        {VEC_LOAD, GR_WR_EN, MAC_WR_EN} <= 3'h0;
        {VEC_SP, VEC_PC, GR_WR_DATA, MAC_HIGH_IN, MAC_LOW_IN} <= ~{a, b, a, a, b};
    endtask
endmodule
`default_nettype wire

//--- cpu_register_set_bench.sv
// Purpose: Self-checking bench of the register set.
// Assumes: Ack comes one cycle after a request is taken.
// Notes:   Reads queue their expected word; a monitor compares.
`timescale 1ns/1ns
`default_nettype none
module cpu_register_set_bench;
    logic        REF_CLK = 0, RST = 1, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0, CTL_WR_EN = 0;
    logic        RESTORE_EN = 0, WB_ACK_O, VEC_LOAD, GR_WR_EN, MAC_WR_EN;
    logic [3:0]  WB_SEL_I = 4'hF, GR_RD_A_IDX = 4'h0, GR_RD_B_IDX = 4'h0, GR_WR_IDX, INTERRUPT_MASK_BITS;
    logic [7:0]  WB_ADR_I = 8'h00, CTL_WR_ADDR = 8'h00, ofs[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    logic [31:0] WB_DAT_I = 0, CTL_WR_DATA = 0, RESTORE_STATUS = 0, RESTORE_PC = 0, WB_DAT_O, VEC_SP, VEC_PC;
    logic [31:0] GR_WR_DATA, MAC_HIGH_IN, MAC_LOW_IN, GR_RD_A_DATA, GR_RD_B_DATA, INDEX_DATA, STACK_PTR;
    logic [31:0] STATUS_WORD, GLOBAL_BASE, VECTOR_BASE, MAC_HIGH, MAC_LOW, SUB_LINK, PROG_COUNTER;
    logic [31:0] r[16], d, expq[$];
    int          err_total = 0, num_checks = 0, seed = 32'hE664;
    cpu_register_set uut (.*);
    cpu_core_model core (.*);
    // Clock of 20 ns.
    always #10 REF_CLK = ~REF_CLK;
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // One classic cycle, held until ack; a read queues its expected word.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] x, input logic [31:0] e);
        @(posedge REF_CLK);
        {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'h3, w, a, x};
        if (!w) expq.push_back(e);
        do @(posedge REF_CLK); while (WB_ACK_O !== 1'b1);
        {WB_CYC_I, WB_STB_I} <= 2'h0;
    endtask
    // Compares each read answer with the oldest expectation.
    always @(posedge REF_CLK) begin
        if (WB_ACK_O === 1'b1 && WB_WE_I === 1'b0) begin
            check("read data", WB_DAT_O, expq.pop_front());
        end
    end
    // Cuts a hang short.
    initial begin
        repeat (3000) @(posedge REF_CLK);
        err_total++;
        stop_test();
    end
    // Main sequence.
    initial begin
        repeat (4) @(posedge REF_CLK);
        RST <= 0;
        wb(0, 8'h00, 0, 32'h0000_00F0);
        check("mask", INTERRUPT_MASK_BITS, 32'hF);
        d = $random(seed);
        core.issue(0, 4'h0, d, ~d);
        @(negedge REF_CLK);
        check("stack", STACK_PTR, d);
        check("pc", PROG_COUNTER, ~d);
        for (int i = 0; i < 16; i++) begin
            r[i] = $random(seed);
            core.issue(1, 4'(i), r[i], 0);
            GR_RD_A_IDX <= 4'(i);
            GR_RD_B_IDX <= 4'(15 - i);
            wb(0, 8'(8'h40 + 4 * i), 0, r[i]);
            check("port a", GR_RD_A_DATA, r[i]);
        end
        check("index", INDEX_DATA, r[0]);
        check("port b", GR_RD_B_DATA, r[0]);
        check("stack", STACK_PTR, r[15]);
        foreach (ofs[j]) begin
            d = $random(seed);
            wb(1, ofs[j], d, 0);
            wb(0, ofs[j], 0, j == 0 ? d & 32'h0000_03F3 : d);
        end
        check("pc", PROG_COUNTER, d);
        core.issue(2, 4'h0, d, ~d);
        wb(0, 8'h0C, 0, d);
        wb(0, 8'h10, 0, ~d);
        check("mac high", MAC_HIGH, d);
        check("mac low", MAC_LOW, ~d);
        {CTL_WR_EN, CTL_WR_ADDR, CTL_WR_DATA} <= {1'b1, 8'h04, d};
        @(posedge REF_CLK);
        {CTL_WR_EN, CTL_WR_ADDR, CTL_WR_DATA} <= {1'b1, 8'h14, ~d};
        {RESTORE_EN, RESTORE_STATUS, RESTORE_PC} <= {1'b1, 32'hFFFF_FFFF, d};
        @(posedge REF_CLK);
        {CTL_WR_EN, RESTORE_EN} <= 2'h0;
        WB_SEL_I <= 4'h3;
        @(negedge REF_CLK);
        check("global base", GLOBAL_BASE, d);
        check("link", SUB_LINK, ~d);
        check("status", STATUS_WORD, 32'h0000_03F3);
        check("pc", PROG_COUNTER, d);
        wb(1, 8'h04, ~d, 0);
        WB_SEL_I <= 4'hF;
        wb(0, 8'h04, 0, {d[31:16], ~d[15:0]});
        wb(0, 8'h3C, 0, 0);
        RST <= 1;
        repeat (2) @(posedge REF_CLK);
        RST <= 0;
        @(negedge REF_CLK);
        check("vector base", VECTOR_BASE, 0);
        check("stack", STACK_PTR, 0);
        check("mask", INTERRUPT_MASK_BITS, 32'hF);
        stop_test();
    end
endmodule
`default_nettype wire
